/* File: cic_pkg.sv */
// Contract
// - control register mirrored at two bank addresses
// - group enable passes unmasked peripheral requests
// - group enable low blocks all peripheral requests
// - timer overflow enable gates its flag
// - external pin enable gates its flag
// - pin change enable gates its flag
// - per-pin enable also needed for change
// - timer rollover sets timer flag
// - external event sets flag, software clears
// - change on pins 5..0 sets flag
// - reset keeps timer count; load before clearing
// - flags set regardless of the interrupt enables; the pin change flag needs a per-pin enable
package cic_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam logic [7:0]  OFF_ICTL_BANK0  = 8'h0b;
  localparam logic [7:0]  OFF_ICTL_BANK1  = 8'h8b;
  localparam logic [7:0]  OFF_EVT_STATUS  = 8'h10;
  localparam logic [7:0]  OFF_EVT_MASK    = 8'h11;
  localparam logic [7:0]  OFF_PIN_ENABLES = 8'h12;
  localparam logic [7:0]  OFF_PIN_LEVEL   = 8'h13;
  localparam logic [7:0]  OFF_PENDING     = 8'h14;

  // ----------------------------------------------------------------
  // interrupt_control fields
  // ----------------------------------------------------------------
  localparam int          BIT_GLOBAL_EN   = 7;
  localparam int          BIT_PERIPH_EN   = 6;
  localparam int          BIT_TIMER_EN    = 5;
  localparam int          BIT_EXTIE       = 4;
  localparam int          BIT_PCIE        = 3;
  localparam int          BIT_TIMER_FLAG  = 2;
  localparam int          BIT_EXTIF       = 1;
  localparam int          BIT_PCIF        = 0;
  localparam logic [7:0]  ICTL_RESET      = 8'h00;

  // ----------------------------------------------------------------
  // pending view bit positions
  // ----------------------------------------------------------------
  localparam int          PEND_COUNT      = 5;
  localparam int          PEND_PIN        = 0;
  localparam int          PEND_EXT        = 1;
  localparam int          PEND_TIMER      = 2;
  localparam int          PEND_PERIPH     = 3;
  localparam int          PEND_CORE       = 4;

  // ----------------------------------------------------------------
  // pins, events and reset values
  // ----------------------------------------------------------------
  localparam int          PIN_COUNT       = 6;
  localparam int          EVT_COUNT       = 4;
  localparam int          EVT_TIMER       = 0;
  localparam int          EVT_EXT         = 1;
  localparam int          EVT_PIN         = 2;
  localparam int          EVT_CORE        = 3;
  localparam logic [7:0]  PIN_EN_RESET    = 8'h00;
  localparam logic [7:0]  EVT_RESET       = 8'h00;

endpackage

/* File: cic_pin_change.sv */
`timescale 1ns/1ns
module cic_pin_change
  import cic_pkg::*;
#(
  parameter int NUM_PINS = PIN_COUNT
)
(
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic [NUM_PINS-1:0] pins,
  input  wire logic [NUM_PINS-1:0] pin_enables,
  output logic                     change
);

  logic [NUM_PINS-1:0] prev_q;
  logic [NUM_PINS-1:0] prev_d;
  logic                primed_q;
  logic                primed_d;
  logic [NUM_PINS-1:0] hit;

  // ----------------------------------------------------------------
  // per-pin compare against last sample
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_PINS; i++)
  begin : g_pin
    assign hit[i] = primed_q & pin_enables[i] & (pins[i] ^ prev_q[i]);
  end

  assign change = |hit;

  always_comb
  begin
    prev_d   = pins;
    primed_d = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_q   <= '0;
      primed_q <= 1'b0;
    end
    else
    begin
      prev_q   <= prev_d;
      primed_q <= primed_d;
    end
  end

endmodule // cic_pin_change

/* File: cic_evt_status.sv */
`timescale 1ns/1ns
module cic_evt_status
  import cic_pkg::*;
#(
  parameter int WIDTH = EVT_COUNT
)
(
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] evt_set,
  input  wire logic             status_wr,
  input  wire logic             mask_wr,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] status_q,
  output logic      [WIDTH-1:0] mask_q,
  output logic                  irq_q
);

  logic [WIDTH-1:0] status_d;
  logic [WIDTH-1:0] mask_d;
  logic             irq_d;
  logic [WIDTH-1:0] clr;

  // ----------------------------------------------------------------
  // sticky status, write one to clear, a new event wins
  // ----------------------------------------------------------------
  always_comb
  begin
    clr      = status_wr ? wdata : '0;
    status_d = (status_q & ~clr) | evt_set;
    mask_d   = mask_wr ? wdata : mask_q;
    irq_d    = |(status_d & mask_d);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_q <= EVT_RESET[WIDTH-1:0];
      mask_q   <= EVT_RESET[WIDTH-1:0];
      irq_q    <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      mask_q   <= mask_d;
      irq_q    <= irq_d;
    end
  end

endmodule // cic_evt_status

/* File: cic_core_irq_ctrl.sv */
`timescale 1ns/1ns
module cic_core_irq_ctrl
  import cic_pkg::*;
#(
  parameter int NUM_PINS = PIN_COUNT
)
(
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [DATA_W-1:0]   reg_rdata,
  input  wire logic                timer_zero_rollover,
  input  wire logic                external_irq_pin,
  input  wire logic [NUM_PINS-1:0] gpio_pins,
  input  wire logic                periph_irq_req,
  output logic                     core_irq_req,
  output logic                     event_irq
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic is_ictl(input logic [ADDR_W-1:0] a);
    is_ictl = (a == OFF_ICTL_BANK0) || (a == OFF_ICTL_BANK1);
  endfunction

  function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] off);
    is_reg = (a == off);
  endfunction

  function automatic logic gated(input logic flag,
                                 input logic en);
    gated = flag & en;
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]   ictl_q;
  logic [DATA_W-1:0]   ictl_d;
  logic [NUM_PINS-1:0] pin_en_q;
  logic [NUM_PINS-1:0] pin_en_d;
  logic [NUM_PINS-1:0] pin_level_q;
  logic [NUM_PINS-1:0] pin_level_d;
  logic                ext_prev_q;
  logic                ext_prev_d;
  logic [DATA_W-1:0]   rdata_q;
  logic [DATA_W-1:0]   rdata_d;
  logic                core_irq_q;
  logic                core_irq_d;

  logic                ictl_wr;
  logic                evt_status_wr;
  logic                evt_mask_wr;
  logic                pin_en_wr;

  logic                timer_event;
  logic                ext_event;
  logic                pin_event;
  logic                core_rise;

  logic                timer_pending;
  logic                ext_pending;
  logic                pin_pending;
  logic                periph_pending;
  logic                any_pending;

  logic [EVT_COUNT-1:0] evt_set;
  logic [EVT_COUNT-1:0] evt_status;
  logic [EVT_COUNT-1:0] evt_mask;
  logic                 evt_irq;
  logic [PEND_COUNT-1:0] pending_vec;

  // ----------------------------------------------------------------
  // write strobes
  // ----------------------------------------------------------------
  assign ictl_wr       = reg_wr && is_ictl(reg_addr);
  assign evt_status_wr = reg_wr && is_reg(reg_addr, OFF_EVT_STATUS);
  assign evt_mask_wr   = reg_wr && is_reg(reg_addr, OFF_EVT_MASK);
  assign pin_en_wr     = reg_wr && is_reg(reg_addr, OFF_PIN_ENABLES);

  // ----------------------------------------------------------------
  // source events
  // ----------------------------------------------------------------
  // the timer count lives outside; only its rollover pulse is seen here,
  // so a reset here never touches the count
  assign timer_event = timer_zero_rollover;

  // external pin interrupt on a rising edge of the pin
  assign ext_event   = external_irq_pin & ~ext_prev_q;

  cic_pin_change #(
    .NUM_PINS    (NUM_PINS)
  ) u_pin_change (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .pins        (gpio_pins),
    .pin_enables (pin_en_q),
    .change      (pin_event)
  );

  always_comb
  begin
    ext_prev_d = external_irq_pin;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_prev_q <= 1'b0;
    end
    else
    begin
      ext_prev_q <= ext_prev_d;
    end
  end

  // ----------------------------------------------------------------
  // pin level snapshot
  // ----------------------------------------------------------------
  // software sees the levels one cycle late, as the change detector does
  always_comb
  begin
    pin_level_d = gpio_pins;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_level_q <= '0;
    end
    else
    begin
      pin_level_q <= pin_level_d;
    end
  end

  // ----------------------------------------------------------------
  // interrupt_control register
  // ----------------------------------------------------------------
  // a flag set in the same cycle as a software write of 0 stays set
  always_comb
  begin
    ictl_d = ictl_q;
    if (ictl_wr)
    begin
      ictl_d = reg_wdata;
    end
    if (timer_event)
    begin
      ictl_d[BIT_TIMER_FLAG] = 1'b1;
    end
    if (ext_event)
    begin
      ictl_d[BIT_EXTIF] = 1'b1;
    end
    if (pin_event)
    begin
      ictl_d[BIT_PCIF] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ictl_q <= ICTL_RESET;
    end
    else
    begin
      ictl_q <= ictl_d;
    end
  end

  // ----------------------------------------------------------------
  // per-pin change enables
  // ----------------------------------------------------------------
  // reset leaves every pin out of the change detector
  always_comb
  begin
    pin_en_d = pin_en_q;
    if (pin_en_wr)
    begin
      pin_en_d = reg_wdata[NUM_PINS-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_en_q <= PIN_EN_RESET[NUM_PINS-1:0];
    end
    else
    begin
      pin_en_q <= pin_en_d;
    end
  end

  // ----------------------------------------------------------------
  // request gating
  // ----------------------------------------------------------------
  assign timer_pending  = gated(ictl_q[BIT_TIMER_FLAG], ictl_q[BIT_TIMER_EN]);
  assign ext_pending    = gated(ictl_q[BIT_EXTIF], ictl_q[BIT_EXTIE]);
  assign pin_pending    = gated(ictl_q[BIT_PCIF], ictl_q[BIT_PCIE]);
  // the peripheral line comes in already masked per source, so only the group enable applies
  assign periph_pending = gated(periph_irq_req, ictl_q[BIT_PERIPH_EN]);

  assign any_pending    = timer_pending | ext_pending | pin_pending | periph_pending;

  // ----------------------------------------------------------------
  // pending view for software
  // ----------------------------------------------------------------
  always_comb
  begin
    pending_vec              = '0;
    pending_vec[PEND_PIN]    = pin_pending;
    pending_vec[PEND_EXT]    = ext_pending;
    pending_vec[PEND_TIMER]  = timer_pending;
    pending_vec[PEND_PERIPH] = periph_pending;
    pending_vec[PEND_CORE]   = core_irq_q;
  end

  // ----------------------------------------------------------------
  // core request register
  // ----------------------------------------------------------------
  always_comb
  begin
    core_irq_d = ictl_q[BIT_GLOBAL_EN] & any_pending;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_irq_q <= 1'b0;
    end
    else
    begin
      core_irq_q <= core_irq_d;
    end
  end

  assign core_irq_req = core_irq_q;

  // ----------------------------------------------------------------
  // event status and mask, one level interrupt
  // ----------------------------------------------------------------
  // a new core request is logged too, so software can tell it was raised
  assign core_rise = core_irq_d & ~core_irq_q;

  always_comb
  begin
    evt_set            = '0;
    evt_set[EVT_TIMER] = timer_event;
    evt_set[EVT_EXT]   = ext_event;
    evt_set[EVT_PIN]   = pin_event;
    evt_set[EVT_CORE]  = core_rise;
  end

  cic_evt_status #(
    .WIDTH     (EVT_COUNT)
  ) u_evt_status (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .evt_set   (evt_set),
    .status_wr (evt_status_wr),
    .mask_wr   (evt_mask_wr),
    .wdata     (reg_wdata[EVT_COUNT-1:0]),
    .status_q  (evt_status),
    .mask_q    (evt_mask),
    .irq_q     (evt_irq)
  );

  assign event_irq = evt_irq;

  // ----------------------------------------------------------------
  // read data, valid the cycle after the read strobe
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_d = '0;
    if (reg_rd)
    begin
      if (is_ictl(reg_addr))
      begin
        rdata_d = ictl_q;
      end
      else
      begin
        unique case (reg_addr)
          OFF_EVT_STATUS:
          begin
            rdata_d[EVT_COUNT-1:0] = evt_status;
          end
          OFF_EVT_MASK:
          begin
            rdata_d[EVT_COUNT-1:0] = evt_mask;
          end
          OFF_PIN_ENABLES:
          begin
            rdata_d[NUM_PINS-1:0] = pin_en_q;
          end
          OFF_PIN_LEVEL:
          begin
            rdata_d[NUM_PINS-1:0] = pin_level_q;
          end
          OFF_PENDING:
          begin
            rdata_d[PEND_COUNT-1:0] = pending_vec;
          end
          default:
          begin
            rdata_d = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule // cic_core_irq_ctrl

/* File: cic_core_irq_ctrl_properties.sv */
`timescale 1ns/1ns
module cic_core_irq_ctrl_chk
  import cic_pkg::*;
#(
  parameter int NUM_PINS = PIN_COUNT
)
(
  input wire logic                clk_sys,
  input wire logic                rst_n,
  input wire logic [ADDR_W-1:0]   reg_addr,
  input wire logic [DATA_W-1:0]   reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [DATA_W-1:0]   reg_rdata,
  input wire logic                timer_zero_rollover,
  input wire logic                external_irq_pin,
  input wire logic [NUM_PINS-1:0] gpio_pins,
  input wire logic                periph_irq_req,
  input wire logic                core_irq_req,
  input wire logic                event_irq
);
  logic [4:0]          en_q;
  logic [3:0]          mask_q;
  logic [NUM_PINS-1:0] pen_q;

  // shadow of the enables, which only software writes
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_q   <= 5'h00;
      mask_q <= 4'h0;
      pen_q  <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == OFF_ICTL_BANK0 || reg_addr == OFF_ICTL_BANK1)
        en_q <= reg_wdata[7:3];
      if (reg_addr == OFF_EVT_MASK)
        mask_q <= reg_wdata[3:0];
      if (reg_addr == OFF_PIN_ENABLES)
        pen_q <= reg_wdata[NUM_PINS-1:0];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_NO_GLOBAL:
  assert property ((($past(en_q) & 5'h10) == 5'h00) |-> !core_irq_req) else $error("request with global off");
  AST_PERIPH_PASS:
  assert property (en_q[4] && en_q[3] && periph_irq_req |=> core_irq_req) else $error("peripheral not passed");
  AST_PERIPH_BLOCK:
  assert property ((($past(en_q) & 5'h0f) == 5'h00) |-> !core_irq_req) else $error("request while blocked");
  AST_TIMER:
  assert property (en_q[4] && en_q[2] && timer_zero_rollover && !reg_wr |-> ##[2:3] core_irq_req)
    else $error("timer request missing");
  AST_EXT:
  assert property (en_q[4] && en_q[1] && $rose(external_irq_pin) && !reg_wr |-> ##[1:3] core_irq_req)
    else $error("external request missing");
  AST_PIN:
  assert property (en_q[4] && en_q[0] && ((gpio_pins ^ $past(gpio_pins)) & pen_q) != '0 && !reg_wr
    |-> ##[1:3] core_irq_req) else $error("pin change request missing");
  AST_RDATA_IDLE:
  assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside read slot");
  AST_EVT_MASKED:
  assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !event_irq) else $error("masked event irq");
endmodule // cic_core_irq_ctrl_chk

bind cic_core_irq_ctrl cic_core_irq_ctrl_chk #(.NUM_PINS(NUM_PINS)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_zero_rollover(timer_zero_rollover),
  .external_irq_pin(external_irq_pin), .gpio_pins(gpio_pins), .periph_irq_req(periph_irq_req),
  .core_irq_req(core_irq_req), .event_irq(event_irq));

/* File: cic_src_model.sv */
`timescale 1ns/1ns
module cic_src_model
  import cic_pkg::*;
(
  input  wire logic            clk_sys,
  output logic                 timer_zero_rollover,
  output logic                 external_irq_pin,
  output logic [PIN_COUNT-1:0] gpio_pins,
  output logic                 periph_irq_req
);
  initial
  begin
    timer_zero_rollover = 1'b0;
    external_irq_pin = 1'b0;
    gpio_pins = '0;
    periph_irq_req = 1'b0;
  end

  // timer count rolls over: one-cycle pulse
  task automatic pulse_timer();
    @(posedge clk_sys);
    timer_zero_rollover <= 1'b1;
    @(posedge clk_sys);
    timer_zero_rollover <= 1'b0;
  endtask

  task automatic set_src(input logic e, input logic [PIN_COUNT-1:0] p, input logic r);
    @(posedge clk_sys);
    external_irq_pin <= e;
    gpio_pins <= p;
    periph_irq_req <= r;
  endtask
endmodule // cic_src_model

/* File: tb_core_interrupt_control.sv */
`timescale 1ns/1ns
module tb_core_interrupt_control
  import cic_pkg::*;
;
  logic                 clk_sys;
  logic                 rst_n;
  logic [ADDR_W-1:0]    reg_addr;
  logic [DATA_W-1:0]    reg_wdata;
  logic                 reg_wr;
  logic                 reg_rd;
  logic [DATA_W-1:0]    reg_rdata;
  logic                 tmr;
  logic                 ext;
  logic [PIN_COUNT-1:0] pins;
  logic                 per;
  logic                 core_irq_req;
  logic                 event_irq;
  int                   err_count;
  int                   check_count;

  cic_core_irq_ctrl u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_zero_rollover(tmr),
    .external_irq_pin(ext), .gpio_pins(pins), .periph_irq_req(per), .core_irq_req(core_irq_req),
    .event_irq(event_irq));
  cic_src_model u_src (.clk_sys(clk_sys), .timer_zero_rollover(tmr), .external_irq_pin(ext),
    .gpio_pins(pins), .periph_irq_req(per));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic final_report();
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic core(input logic e);
    cmp("core_irq_req", {7'h00, e}, {7'h00, core_irq_req});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    cmp($sformatf("rdata_%h", a), e, reg_rdata);
  endtask

  task automatic s_regs();
    rd(OFF_ICTL_BANK0, 8'h00);
    rd(8'h20, 8'h00);
    wr(OFF_ICTL_BANK0, 8'h5a);
    rd(OFF_ICTL_BANK1, 8'h5a);
    wr(OFF_ICTL_BANK1, 8'h35);
    rd(OFF_ICTL_BANK0, 8'h35);
  endtask

  task automatic s_timer();
    wr(OFF_ICTL_BANK0, 8'h00);
    u_src.pulse_timer();
    idle(3);
    rd(OFF_ICTL_BANK0, 8'h04);
    core(1'b0);
    wr(OFF_ICTL_BANK0, 8'h00);
    wr(OFF_ICTL_BANK0, 8'ha0);
    u_src.pulse_timer();
    idle(3);
    core(1'b1);
    rd(OFF_ICTL_BANK0, 8'ha4);
    wr(OFF_ICTL_BANK1, 8'h20);
    u_src.pulse_timer();
    idle(3);
    core(1'b0);
    rd(OFF_ICTL_BANK0, 8'h24);
  endtask

  task automatic s_ext();
    wr(OFF_ICTL_BANK0, 8'h90);
    u_src.set_src(1'b1, 6'h00, 1'b0);
    idle(4);
    core(1'b1);
    idle(3);
    rd(OFF_ICTL_BANK0, 8'h92);
    wr(OFF_ICTL_BANK0, 8'h80);
    u_src.set_src(1'b0, 6'h00, 1'b0);
    idle(3);
    rd(OFF_ICTL_BANK0, 8'h80);
    core(1'b0);
  endtask

  task automatic s_pin();
    wr(OFF_ICTL_BANK0, 8'h88);
    u_src.set_src(1'b0, 6'h20, 1'b0);
    idle(3);
    rd(OFF_ICTL_BANK0, 8'h88);
    wr(OFF_PIN_ENABLES, 8'h3f);
    u_src.set_src(1'b0, 6'h21, 1'b0);
    idle(3);
    rd(OFF_ICTL_BANK0, 8'h89);
    core(1'b1);
    rd(OFF_PIN_ENABLES, 8'h3f);
    rd(OFF_PIN_LEVEL, 8'h21);
    rd(OFF_PENDING, 8'h11);
    wr(OFF_ICTL_BANK0, 8'h80);
    idle(3);
    core(1'b0);
  endtask

  task automatic s_periph();
    u_src.set_src(1'b0, 6'h21, 1'b1);
    idle(3);
    core(1'b0);
    rd(OFF_PENDING, 8'h00);
    wr(OFF_ICTL_BANK0, 8'hc0);
    idle(3);
    core(1'b1);
    rd(OFF_PENDING, 8'h18);
    u_src.set_src(1'b0, 6'h21, 1'b0);
    wr(OFF_ICTL_BANK0, 8'h00);
  endtask

  task automatic s_events();
    rd(OFF_EVT_STATUS, 8'h0f);
    wr(OFF_EVT_STATUS, 8'h0f);
    rd(OFF_EVT_STATUS, 8'h00);
    wr(OFF_EVT_MASK, 8'h02);
    rd(OFF_EVT_MASK, 8'h02);
    u_src.pulse_timer();
    idle(3);
    cmp("event_irq", 8'h00, {7'h00, event_irq});
    rd(OFF_EVT_STATUS, 8'h01);
    wr(OFF_EVT_MASK, 8'h01);
    idle(2);
    cmp("event_irq", 8'h01, {7'h00, event_irq});
    wr(OFF_EVT_STATUS, 8'h01);
    idle(2);
    cmp("event_irq", 8'h00, {7'h00, event_irq});
    rd(OFF_EVT_STATUS, 8'h00);
  endtask

  initial
  begin
    err_count = 0;
    check_count = 0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    s_regs();
    s_timer();
    s_ext();
    s_pin();
    s_periph();
    s_events();
    final_report();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    final_report();
  end
endmodule // tb_core_interrupt_control
